// ### src/adc_serial_control.sv
`timescale 1ns/1ps
// Overview of operation
// - Stop 32 cycles early halts further conversions.
// - Commands accepted anytime outside the reset recovery wait, regardless of ready timing.
// - Ready rises within five cycles of trigger.
// - Ready stays high at least 24 cycles.
// - Incomplete byte after 2^15 cycles resets interface.
// - Output levels update within 100 ns.
// - Input bits sampled on serial clock falling edges.
// - Output bits shift on serial clock rising edges.
// - Output driven while select low, else released.
// - Back to back bytes and commands accepted.
module adc_serial_control import adc_ctrl_pkg::*; #(
   parameter int CONV_CYCLES = CONV_CYCLES_DEF,
   parameter int RESET_WAIT  = RESET_WAIT_CYC,
   parameter int TIMEOUT     = TIMEOUT_CYC,
   parameter int RESULT_W    = RESULT_W_DEF,
   parameter int GPIO_W      = GPIO_W_DEF
)(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              sclk,
   input  wire logic              csN,
   input  wire logic              din,
   output logic                   dout,
   output logic                   doutOe,
   input  wire logic              startPin,
   input  wire logic              resetPinN,
   output logic                   resultReadyN,
   output logic [GPIO_W-1:0]      generalIoOutputs
);
   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam int WW = $clog2(RESET_WAIT + 1);
   localparam int TW = $clog2(TIMEOUT + 1);

   link_if #(.RESULT_W(RESULT_W)) lnk ();

   logic [4:0] lvl, chg;

   // ==========================================================================
   // Serial link logic on the serial clock.
   serial_link #(.RESULT_W(RESULT_W)) u_link (
      .sclk (sclk),
      .csN  (csN),
      .din  (din),
      .dout (dout),
      .lnk  (lnk)
   );

   assign doutOe = ~csN;

   // ==========================================================================
   // Pin and link flag synchronisers.
   pin_sync #(.W(5), .INIT(SYNC_INIT)) u_sync (
      .clk     (clk),
      .nrst    (nrst),
      .d       ({csN, startPin, resetPinN, lnk.bitTog, lnk.riseTog}),
      .level   (lvl),
      .changed (chg)
   );

   function automatic logic match7(input logic [6:0] bits, input logic [7:0] cmd);
      match7 = (bits == cmd[7:1]);
   endfunction

   logic csLow, csEdge, startRise, startFall, rstRise, recovered;
   logic bitEvt, riseEvt;

   always_comb begin
      csLow     = ~lvl[LANE_CS];
      csEdge    = chg[LANE_CS];
      startRise = chg[LANE_START] & lvl[LANE_START];
      startFall = chg[LANE_START] & ~lvl[LANE_START];
      rstRise   = chg[LANE_RSTPIN] & lvl[LANE_RSTPIN];
   end

   // ==========================================================================
   // Hardware reset filter and recovery wait.
   logic [2:0]    rstLowCnt_r, rstLowCnt_nxt;
   logic [WW-1:0] waitCnt_r, waitCnt_nxt;
   logic          pinRst, resetCmd, softRst;

   always_comb begin
      pinRst        = ~lvl[LANE_RSTPIN] && (rstLowCnt_r == 3'(RESET_LOW_MIN - 1));
      softRst       = pinRst | resetCmd;
      rstLowCnt_nxt = 3'h0;
      if (!lvl[LANE_RSTPIN]) begin
         rstLowCnt_nxt = pinRst ? rstLowCnt_r : rstLowCnt_r + 3'h1;
      end
      waitCnt_nxt = (waitCnt_r == '0) ? waitCnt_r : waitCnt_r - WW'(1);
      if (softRst) begin
         waitCnt_nxt = WW'(RESET_WAIT);
      end
      recovered = (waitCnt_r == '0);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rstLowCnt_r <= 3'h0;
         waitCnt_r   <= '0;
      end else begin
         rstLowCnt_r <= rstLowCnt_nxt;
         waitCnt_r   <= waitCnt_nxt;
      end
   end

   // ==========================================================================
   // Byte assembly, timeout and command parsing.
   logic [7:0]        rxByte_r, rxByte_nxt;
   logic [3:0]        rxCnt_r, rxCnt_nxt;
   logic [TW-1:0]     toCnt_r, toCnt_nxt;
   parse_t            state_r, state_nxt;
   logic [4:0]        wrAddr_r, wrAddr_nxt;
   logic [7:0]        wrLeft_r, wrLeft_nxt;
   logic [GPIO_W-1:0] gpio_r, gpio_nxt;
   logic              single_r, single_nxt;
   logic [7:0]        shifted;
   logic              byteDone, startCmd, stopCmd;

   always_comb begin
      bitEvt     = chg[LANE_BIT] & csLow & ~csEdge & recovered;
      riseEvt    = chg[LANE_RISE] & csLow & ~csEdge;
      shifted    = {rxByte_r[6:0], lnk.bitVal};
      rxByte_nxt = rxByte_r;
      rxCnt_nxt  = rxCnt_r;
      toCnt_nxt  = '0;
      state_nxt  = state_r;
      wrAddr_nxt = wrAddr_r;
      wrLeft_nxt = wrLeft_r;
      gpio_nxt   = gpio_r;
      single_nxt = single_r;
      byteDone   = 1'b0;
      startCmd   = 1'b0;
      stopCmd    = 1'b0;
      resetCmd   = 1'b0;
      if (bitEvt) begin
         rxByte_nxt = shifted;
         rxCnt_nxt  = rxCnt_r + 4'h1;
         if (rxCnt_r == 4'h6 && state_r == PARSE_IDLE) begin
            resetCmd = match7(shifted[6:0], CMD_RESET);
            stopCmd  = match7(shifted[6:0], CMD_STOP);
         end
         if (rxCnt_r == 4'h7) begin
            byteDone  = 1'b1;
            rxCnt_nxt = 4'h0;
         end
      end else if (rxCnt_r != 4'h0) begin
         toCnt_nxt = toCnt_r + TW'(1);
      end
      if (byteDone) begin
         unique case (state_r)
            PARSE_IDLE: begin
               startCmd = (shifted == CMD_START);
               if (shifted[7:5] == CMD_REGISTER_WRITE_COMMAND_TOP) begin
                  wrAddr_nxt = shifted[4:0];
                  state_nxt  = PARSE_COUNT;
               end
            end
            PARSE_COUNT: begin
               wrLeft_nxt = shifted;
               state_nxt  = PARSE_DATA;
            end
            PARSE_DATA: begin
               if (wrAddr_r == GPIO_REG_ADDR) begin
                  gpio_nxt = shifted[GPIO_W-1:0];
               end
               if (wrAddr_r == MODE_REG_ADDR) begin
                  single_nxt = shifted[MODE_SINGLE_BIT];
               end
               wrAddr_nxt = wrAddr_r + 5'h01;
               wrLeft_nxt = wrLeft_r - 8'h01;
               if (wrLeft_r == 8'h00) begin
                  state_nxt = PARSE_IDLE;
               end
            end
         endcase
      end
      if (!csLow || toCnt_r == TW'(TIMEOUT - 1)) begin
         rxCnt_nxt = 4'h0;
         toCnt_nxt = '0;
         state_nxt = PARSE_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || softRst) begin
         rxByte_r <= 8'h00;
         rxCnt_r  <= 4'h0;
         toCnt_r  <= '0;
         state_r  <= PARSE_IDLE;
         wrAddr_r <= 5'h00;
         wrLeft_r <= 8'h00;
         gpio_r   <= GPIO_RST[GPIO_W-1:0];
         single_r <= SINGLE_RST;
      end else begin
         rxByte_r <= rxByte_nxt;
         rxCnt_r  <= rxCnt_nxt;
         toCnt_r  <= toCnt_nxt;
         state_r  <= state_nxt;
         wrAddr_r <= wrAddr_nxt;
         wrLeft_r <= wrLeft_nxt;
         gpio_r   <= gpio_nxt;
         single_r <= single_nxt;
      end
   end

   // ==========================================================================
   // Conversion sequencing and result ready output.
   logic                converting_r, converting_nxt;
   logic [CW-1:0]       convCnt_r, convCnt_nxt;
   logic                stopNow_r, stopNow_nxt, stopNext_r, stopNext_nxt;
   logic                pend_r, pend_nxt, result_ready_n_r, result_ready_n_nxt;
   logic [4:0]          drCnt_r, drCnt_nxt;
   logic [RESULT_W-1:0] result_r, result_nxt, txWord_r, txWord_nxt;
   logic                stopReq, convDone;
   logic [CW-1:0]       remain;

   always_comb begin
      converting_nxt = converting_r;
      convCnt_nxt    = convCnt_r;
      stopNow_nxt    = stopNow_r;
      stopNext_nxt   = stopNext_r;
      pend_nxt       = pend_r;
      result_ready_n_nxt       = result_ready_n_r;
      drCnt_nxt      = (drCnt_r == 5'h1F) ? drCnt_r : drCnt_r + 5'h01;
      result_nxt     = result_r;
      txWord_nxt     = txWord_r;
      remain         = CW'(CONV_CYCLES - 1) - convCnt_r;
      stopReq        = converting_r && (stopCmd || (startFall && !single_r));
      convDone       = converting_r && (convCnt_r == CW'(CONV_CYCLES - 1));
      if (converting_r) begin
         convCnt_nxt = convCnt_r + CW'(1);
      end
      if (stopReq) begin
         if (remain >= CW'(STOP_SETUP)) begin
            stopNow_nxt = 1'b1;
         end else begin
            stopNext_nxt = 1'b1;
         end
      end
      if (convDone) begin
         convCnt_nxt = '0;
         result_nxt  = result_r + RESULT_W'(1);
         pend_nxt    = 1'b1;
         if (single_r || stopNow_r || (stopReq && remain >= CW'(STOP_SETUP))) begin
            converting_nxt = 1'b0;
            stopNow_nxt    = 1'b0;
            stopNext_nxt   = 1'b0;
         end else if (stopNext_r || stopReq) begin
            stopNow_nxt  = 1'b1;
            stopNext_nxt = 1'b0;
         end
         if (!result_ready_n_r) begin
            result_ready_n_nxt  = 1'b1;
            drCnt_nxt = 5'h00;
         end
      end
      if (startRise || startCmd) begin
         converting_nxt = 1'b1;
         convCnt_nxt    = '0;
         stopNow_nxt    = 1'b0;
         stopNext_nxt   = 1'b0;
      end
      if (pend_r && result_ready_n_r && drCnt_r >= 5'(RESULT_READY_N_HIGH_MIN - 1)
          && !startRise && !riseEvt) begin
         result_ready_n_nxt   = 1'b0;
         pend_nxt   = convDone;
         txWord_nxt = result_r;
      end
      if ((startRise || riseEvt) && !result_ready_n_r) begin
         result_ready_n_nxt  = 1'b1;
         drCnt_nxt = 5'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || softRst) begin
         converting_r <= 1'b0;
         convCnt_r    <= '0;
         stopNow_r    <= 1'b0;
         stopNext_r   <= 1'b0;
         pend_r       <= 1'b0;
         result_ready_n_r       <= 1'b1;
         drCnt_r      <= 5'h00;
         result_r     <= '0;
         txWord_r     <= '0;
      end else begin
         converting_r <= converting_nxt;
         convCnt_r    <= convCnt_nxt;
         stopNow_r    <= stopNow_nxt;
         stopNext_r   <= stopNext_nxt;
         pend_r       <= pend_nxt;
         result_ready_n_r       <= result_ready_n_nxt;
         drCnt_r      <= drCnt_nxt;
         result_r     <= result_nxt;
         txWord_r     <= txWord_nxt;
      end
   end

   assign lnk.txWord       = txWord_r;
   assign resultReadyN     = result_ready_n_r;
   assign generalIoOutputs = gpio_r;
endmodule

// ### src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

   // ==========================================================================
   // Clock and timing.
   localparam int          CLK_HZ          = 50_000_000;
   localparam int          RESET_LOW_MIN   = 4;
   localparam int          RESET_WAIT_CYC  = 4096;
   localparam int          TRIG_PHASE_MIN  = 4;
   localparam int          STOP_SETUP      = 32;
   localparam int          DIRECT_HOLD_MIN = 28;
   localparam int          DIRECT_SETUP    = 4;
   localparam int          RESULT_READY_N_RISE_MAX   = 2;
   localparam int          RESULT_READY_N_HIGH_MIN   = 24;
   localparam int          TIMEOUT_CYC     = 32768;
   localparam int          GPIO_DELAY_NS   = 100;
   localparam int          GPIO_DELAY_CYC  = (GPIO_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int          CONV_CYCLES_DEF = 2048;

   // ==========================================================================
   // Widths and reset values.
   localparam int          RESULT_W_DEF    = 16;
   localparam int          GPIO_W_DEF      = 4;
   localparam logic [3:0]  GPIO_RST        = 4'h0;
   localparam logic        SINGLE_RST      = 1'b0;
   localparam logic [4:0]  SYNC_INIT       = 5'h14;

   // ==========================================================================
   // Synchroniser lanes.
   localparam int          LANE_CS         = 4;
   localparam int          LANE_START      = 3;
   localparam int          LANE_RSTPIN     = 2;
   localparam int          LANE_BIT        = 1;
   localparam int          LANE_RISE       = 0;

   // ==========================================================================
   // Command set and register addresses.
   localparam logic [7:0]  CMD_RESET       = 8'hA0;
   localparam logic [7:0]  CMD_START       = 8'hA4;
   localparam logic [7:0]  CMD_STOP        = 8'hA8;
   localparam logic [7:0]  CMD_RDATA       = 8'hB0;
   localparam logic [2:0]  CMD_REGISTER_WRITE_COMMAND_TOP    = 3'h3;
   localparam logic [4:0]  MODE_REG_ADDR   = 5'h04;
   localparam logic [4:0]  GPIO_REG_ADDR   = 5'h10;
   localparam int          MODE_SINGLE_BIT = 0;

   typedef enum logic [1:0] {
      PARSE_IDLE,
      PARSE_COUNT,
      PARSE_DATA
   } parse_t;

endpackage

// ### src/link_if.sv
`timescale 1ns/1ps
interface link_if #(parameter int RESULT_W = 16);
   logic                bitVal;
   logic                bitTog;
   logic                riseTog;
   logic [RESULT_W-1:0] txWord;

   modport link (output bitVal, output bitTog, output riseTog, input txWord);
   modport core (input bitVal, input bitTog, input riseTog, output txWord);
endinterface

// ### src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int           W    = 5,
   parameter logic [W-1:0] INIT = '0
)(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] level,
   output logic      [W-1:0] changed
);
   logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, chg_r;
   logic [W-1:0] lvl_nxt, chg_nxt;

   // ==========================================================================
   // A change counts once the second and third stages agree.
   always_comb begin
      lvl_nxt = lvl_r;
      chg_nxt = '0;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i] && s3_r[i] != lvl_r[i]) begin
            lvl_nxt[i] = s3_r[i];
            chg_nxt[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_r  <= INIT;
         s2_r  <= INIT;
         s3_r  <= INIT;
         lvl_r <= INIT;
         chg_r <= '0;
      end else begin
         s1_r  <= d;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
         chg_r <= chg_nxt;
      end
   end

   assign level   = lvl_r;
   assign changed = chg_r;
endmodule

// ### src/serial_link.sv
`timescale 1ns/1ps
module serial_link import adc_ctrl_pkg::*; #(
   parameter int RESULT_W = RESULT_W_DEF
)(
   input  wire logic sclk,
   input  wire logic csN,
   input  wire logic din,
   output logic      dout,
   link_if.link      lnk
);
   logic       bitVal_r, bitVal_nxt, bitTog_r, bitTog_nxt;
   logic [4:0] idx_r, idx_nxt;
   logic       riseTog_r, riseTog_nxt, dout_r, dout_nxt;

   // ==========================================================================
   // Falling edge: capture one input bit and flag it.
   always_comb begin
      bitVal_nxt = din;
      bitTog_nxt = ~bitTog_r;
   end

   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         bitVal_r <= 1'b0;
         bitTog_r <= 1'b0;
      end else begin
         bitVal_r <= bitVal_nxt;
         bitTog_r <= bitTog_nxt;
      end
   end

   // ==========================================================================
   // Rising edge: shift out the next result bit and flag byte starts.
   always_comb begin
      idx_nxt     = (idx_r == 5'h1F) ? idx_r : idx_r + 5'h01;
      riseTog_nxt = (idx_r[2:0] == 3'h0) ? ~riseTog_r : riseTog_r;
      dout_nxt    = 1'b0;
      if (int'(idx_r) < RESULT_W) begin
         dout_nxt = lnk.txWord[RESULT_W-1-int'(idx_r)];
      end
   end

   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         idx_r     <= 5'h00;
         riseTog_r <= 1'b0;
         dout_r    <= 1'b0;
      end else begin
         idx_r     <= idx_nxt;
         riseTog_r <= riseTog_nxt;
         dout_r    <= dout_nxt;
      end
   end

   assign lnk.bitVal  = bitVal_r;
   assign lnk.bitTog  = bitTog_r;
   assign lnk.riseTog = riseTog_r;
   assign dout        = dout_r;
endmodule

// ### dv/adc_serial_control_sva.sv
`timescale 1ns/1ps
module adc_serial_control_sva import adc_ctrl_pkg::*; #(
   parameter int GPIO_W = GPIO_W_DEF
)(
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              sclk,
   input wire logic              csN,
   input wire logic              din,
   input wire logic              dout,
   input wire logic              doutOe,
   input wire logic              startPin,
   input wire logic              resetPinN,
   input wire logic              resultReadyN,
   input wire logic [GPIO_W-1:0] generalIoOutputs
);
   logic [5:0] hiCnt_r;
   logic [4:0] quietCnt_r;
   logic       sclkQ_r;
   logic       firstPend_r;

   // ==========================================
   // Helper counters in master clock periods.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hiCnt_r     <= 6'h00;
         quietCnt_r  <= 5'h00;
         sclkQ_r     <= 1'b0;
         firstPend_r <= 1'b1;
      end else begin
         hiCnt_r     <= resultReadyN ? hiCnt_r + {5'h00, hiCnt_r != 6'h3F} : 6'h00;
         quietCnt_r  <= (csN && resetPinN) ? quietCnt_r + {4'h0, quietCnt_r != 5'h1F}
                                           : 5'h00;
         sclkQ_r     <= sclk;
         firstPend_r <= csN ? 1'b1 : (sclk ? 1'b0 : firstPend_r);
      end
   end

   // ==========================================
   // Assertions.
   oe_tracks_cs_a: assert property (@(posedge clk) disable iff (!nrst)
      doutOe == !csN) else $error("output enable differs from select");
   out_released_a: assert property (@(posedge clk) disable iff (!nrst)
      csN && $past(csN) |-> !dout && !doutOe) else $error("data out not released");
   drive_start_a: assert property (@(posedge clk) disable iff (!nrst)
      $fell(csN) |-> doutOe && !dout) else $error("data out wrong at select");
   dout_edge_a: assert property (@(posedge clk) disable iff (!nrst)
      !csN && $changed(dout) |-> sclk) else $error("data out moved off rising edge");
   ready_start_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(startPin) |-> ##[1:7] resultReadyN) else $error("ready late after trigger");
   ready_sclk_a: assert property (@(posedge clk) disable iff (!nrst)
      !csN && sclk && !sclkQ_r && firstPend_r |-> ##[1:7] resultReadyN)
      else $error("ready late after serial clock");
   ready_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      $fell(resultReadyN) |-> hiCnt_r >= 6'h18) else $error("ready high too short");
   gpio_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
      quietCnt_r >= 5'h0C |-> $stable(generalIoOutputs)) else $error("outputs moved idle");
endmodule

bind adc_serial_control adc_serial_control_sva #(.GPIO_W(GPIO_W)) u_sva (
   .clk(clk), .nrst(nrst), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
   .doutOe(doutOe), .startPin(startPin), .resetPinN(resetPinN),
   .resultReadyN(resultReadyN), .generalIoOutputs(generalIoOutputs)
);

// ### dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model #(
   parameter int RESET_WAIT = 16
)(
   input wire logic clk,
   input wire logic dout,
   input wire logic doutOe,
   output logic     sclk,
   output logic     csN,
   output logic     din,
   output logic     startPin,
   output logic     resetPinN
);
   wire sdo = doutOe ? dout : 1'b0;

   initial begin
      sclk      = 1'b0;
      csN       = 1'b1;
      din       = 1'b0;
      startPin  = 1'b0;
      resetPinN = 1'b1;
   end

   // ==========================================
   // Pin and frame tasks.
   task automatic hw_reset();
      @(posedge clk) resetPinN <= 1'b0;
      repeat (4) @(posedge clk);
      resetPinN <= 1'b1;
      repeat (RESET_WAIT + 8) @(posedge clk);
   endtask

   task automatic trig(input logic v);
      @(posedge clk) startPin <= v;
      repeat (6) @(posedge clk);
   endtask

   task automatic frame(input logic v);
      #33.3;
      csN <= v;
      #27.1;
      if (v) din <= ~din;
   endtask

   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < nb; i++) begin
         sclk <= 1'b1;
         #20;
         din <= tx[7-i];
         #42.5;
         rx[7-i] = sdo;
         sclk <= 1'b0;
         #62.5;
      end
   endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench import adc_ctrl_pkg::*;;
   localparam int CONV  = 400;
   localparam int RWAIT = 16;
   localparam int TOUT  = 64;
   logic        clk;
   logic        nrst;
   logic        sclk;
   logic        csN;
   logic        din;
   logic        dout;
   logic        doutOe;
   logic        startPin;
   logic        resetPinN;
   logic        resultReadyN;
   logic [3:0]  generalIoOutputs;
   logic [15:0] w1;
   logic [15:0] w2;
   logic [7:0]  rx;
   logic [7:0]  g;
   logic [15:0] gExp;
   int          error_cnt;
   int          n_checks;
   int          seed;
   int          falls;
   int          f0;

   initial clk = 1'b0;
   always #10 clk = ~clk;
   always @(negedge resultReadyN) if (nrst) falls = falls + 1;

   adc_serial_control #(.CONV_CYCLES(CONV), .RESET_WAIT(RWAIT), .TIMEOUT(TOUT))
   u_adc_serial_control (
      .clk(clk), .nrst(nrst), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
      .doutOe(doutOe), .startPin(startPin), .resetPinN(resetPinN),
      .resultReadyN(resultReadyN), .generalIoOutputs(generalIoOutputs)
   );

   spi_host_model host (
      .clk(clk), .dout(dout), .doutOe(doutOe), .sclk(sclk), .csN(csN), .din(din),
      .startPin(startPin), .resetPinN(resetPinN)
   );

   // ==========================================
   // Expectations and checking.
   function automatic logic [15:0] exp_gpio(input logic [7:0] d);
      return {12'h000, d[3:0]};
   endfunction

   function automatic logic [15:0] exp_next(input logic [15:0] w);
      return w + 16'h0001;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wait_fall();
      f0 = falls;
      repeat (2 * CONV) if (falls == f0) @(posedge clk);
      check(16'(falls != f0), 16'h0001);
      repeat (6) @(posedge clk);
   endtask

   task automatic read_word(output logic [15:0] w);
      logic [7:0] hi;
      host.frame(1'b0);
      host.xfer(8'h00, 8, hi);
      host.xfer(8'h00, 8, rx);
      host.frame(1'b1);
      w = {hi, rx};
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] n, input logic [7:0] d);
      host.frame(1'b0);
      host.xfer({CMD_REGISTER_WRITE_COMMAND_TOP, a}, 8, rx);
      host.xfer(n, 8, rx);
      if (n == 8'h01) host.xfer(8'h5A, 8, rx);
      host.xfer(d, 8, rx);
      if (5'(a + n) == GPIO_REG_ADDR) gExp = exp_gpio(d);
      #38;
      check(16'(generalIoOutputs), gExp);
      host.frame(1'b1);
   endtask

   task automatic cmd(input logic [7:0] c);
      host.frame(1'b0);
      host.xfer(c, 8, rx);
      host.frame(1'b1);
   endtask

   // ==========================================
   // Main sequence.
   initial begin
      seed      = 17696;
      nrst      = 1'b0;
      error_cnt = 0;
      n_checks  = 0;
      falls     = 0;
      gExp      = 16'h0000;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      check(16'(doutOe), 16'h0000);
      check(16'(generalIoOutputs), 16'h0000);
      host.hw_reset();
      host.trig(1'b1);
      wait_fall();
      read_word(w1);
      wait_fall();
      read_word(w2);
      check(w2, exp_next(w1));
      for (int i = 0; i < 6; i++) begin
         repeat (8 + ({$random(seed)} % 60)) @(posedge clk);
         g = 8'($random(seed));
         wr(i == 0 ? 5'h0F : GPIO_REG_ADDR, i == 0 ? 8'h01 : 8'h00, g);
      end
      host.frame(1'b0);
      host.xfer(8'h70, 4, rx);
      repeat (TOUT + 10) @(posedge clk);
      wr(GPIO_REG_ADDR, 8'h00, 8'hC9);
      wait_fall();
      host.trig(1'b0);
      f0 = falls;
      repeat (3 * CONV) @(posedge clk);
      check(16'(falls - f0), 16'h0001);
      host.trig(1'b1);
      wait_fall();
      repeat (CONV - 26) @(posedge clk);
      host.trig(1'b0);
      f0 = falls;
      repeat (3 * CONV) @(posedge clk);
      check(16'(falls - f0), 16'h0002);
      cmd(CMD_START);
      wait_fall();
      cmd(CMD_STOP);
      f0 = falls;
      repeat (3 * CONV) @(posedge clk);
      check(16'(falls - f0), 16'h0001);
      wr(MODE_REG_ADDR, 8'h00, 8'h01);
      f0 = falls;
      host.trig(1'b1);
      repeat (3 * CONV) @(posedge clk);
      check(16'(falls - f0), 16'h0001);
      cmd(CMD_RESET);
      repeat (RWAIT + 8) @(posedge clk);
      gExp = 16'h0000;
      check(16'(generalIoOutputs), gExp);
      wr(GPIO_REG_ADDR, 8'h00, g | 8'h01);
      host.hw_reset();
      gExp = 16'h0000;
      check(16'(generalIoOutputs), gExp);
      summarize();
   end

   initial begin
      #300000;
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      summarize();
   end
endmodule
